// [rtl/fbp_defs.svh]
// Constants for the flash block protection block
`ifndef FBP_DEFS_SVH
`define FBP_DEFS_SVH
// How it works
// - Protection runs from the start address formed from the protect byte up to FFFF.
// - High-voltage enable is refused in program and in erase without mass when the latched address is protected.
// - The vector page is always protected as the latched target; there only a mass erase can touch it.
// - A protect byte of 20 puts the start at 9000, locking the whole user array.
// - Protect bytes 00-1F and E0-FF leave the whole user array open; only the vectors and a written protect byte stay locked.
// - A protect byte other than FF protects itself as the latched target; there only a mass erase can change it.
// - The start address is 1, the eight protect bits at 14:7, then seven zeros.
// - The start address thus always falls on a 128-byte page boundary.
// - The protect byte lives in the array, changes only by programming or mass erase, and survives reset.
// - User array is 9000-EFFF and the vector page is FFD0-FFFF.
// - High-voltage enable can be set only with a select bit on and the sequence followed.
`define FBP_CTRL_ADDR     16'hFE08
`define FBP_BOUNDARY_ADDR 16'hFFCF
`define FBP_USER_LO       16'h9000
`define FBP_USER_HI       16'hEFFF
`define FBP_VECT_LO       16'hFFD0
`define FBP_OPEN_LO_MAX   8'h1F
`define FBP_OPEN_HI_MIN   8'hE0
`define FBP_ERASED        8'hFF
`define FBP_HIGH_VOLTAGE_ENABLE_BIT      3
`define FBP_MASS_BIT      2
`define FBP_ERASE_BIT     1
`define FBP_PGM_BIT       0
`define FBP_CTRL_RESET    8'h00
`endif

// [rtl/fbp_pkg.sv]
// Types for the flash block protection block
`default_nettype none
package fbp_pkg;
  typedef enum logic [1:0] {FBP_IDLE, FBP_SELECTED, FBP_READ_DONE, FBP_LATCHED} fbp_seq_t;
  typedef struct packed {
    logic        high_voltage_enable;
    logic        mass;
    logic        erase;
    logic        program_select;
  } fbp_ctrl_t;
endpackage
`default_nettype wire

// [rtl/fbp_protect.sv]
// Flash block protection: control register, sequence tracking and high-voltage gating
`include "fbp_defs.svh"
`default_nettype none
module fbp_protect
  import fbp_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [7:0]        rdata,
  input  wire logic [7:0]        boundary_bits,
  output logic                   nv_write,
  output logic      [ADDR_W-1:0] nv_addr,
  output logic      [7:0]        nv_data,
  output logic                   high_voltage_enable,
  output logic                   program_select,
  output logic                   erase_select,
  output logic                   mass_select,
  output logic                   target_blocked
);
  // Address decoding below is written for a 16-bit space only
  if (ADDR_W != 16) begin : g_addr_check
    $error("fbp_protect supports only a 16-bit address");
  end

  ////////////////////////////////////////////////////////////////////////////
  fbp_ctrl_t   ctrl, next_ctrl;
  fbp_seq_t    seq, next_seq;
  logic [15:0] latch_addr, next_latch_addr;
  logic [7:0]  rdata_q, next_rdata;
  logic [15:0] start_addr;
  logic        open_all, in_flash, prot_hit, blocked;
  logic        ctrl_wr, flash_wr;
  // The latched target decides protection until the sequence restarts

  // Fixed top bit, the protect byte, then a page-aligned zero tail
  assign start_addr = {1'b1, boundary_bits, 7'h00};
  // Byte values whose start would miss the user array leave it all open
  assign open_all   = (boundary_bits <= `FBP_OPEN_LO_MAX) ||
                      (boundary_bits >= `FBP_OPEN_HI_MIN);
  assign in_flash   = ((addr >= `FBP_USER_LO) && (addr <= `FBP_USER_HI)) ||
                      (addr >= `FBP_VECT_LO) || (addr == `FBP_BOUNDARY_ADDR);
  assign ctrl_wr    = wr && (addr == `FBP_CTRL_ADDR);
  assign flash_wr   = wr && in_flash;

  // Vectors and a written boundary byte are locked regardless; mass erase bypasses all locks
  always_comb begin
    prot_hit = 1'b0;
    if (latch_addr >= `FBP_VECT_LO) prot_hit = 1'b1;
    if ((latch_addr == `FBP_BOUNDARY_ADDR) && (boundary_bits != `FBP_ERASED))
      prot_hit = 1'b1;
    if (!open_all && (latch_addr >= start_addr)) prot_hit = 1'b1;
  end
  // Mass erase must reach the vectors and the boundary byte, so it passes every lock
  assign blocked = prot_hit && !(ctrl.erase && ctrl.mass);

  ////////////////////////////////////////////////////////////////////////////
  // Sequence: select, read boundary, dummy write latches target, then HIGH_VOLTAGE_ENABLE
  always_comb begin
    next_ctrl       = ctrl;
    next_seq        = seq;
    next_latch_addr = latch_addr;
    next_rdata      = 8'h00;
    // With both select bits clear the sequence always falls back to idle
    if (!(ctrl.program_select || ctrl.erase)) next_seq = FBP_IDLE;
    case (seq)
      FBP_IDLE:      if (ctrl.program_select || ctrl.erase) begin
        // A boundary read right behind the select write already counts
        if (rd && (addr == `FBP_BOUNDARY_ADDR)) next_seq = FBP_READ_DONE;
        else next_seq = FBP_SELECTED;
      end
      FBP_SELECTED:  if (rd && (addr == `FBP_BOUNDARY_ADDR)) next_seq = FBP_READ_DONE;
      FBP_READ_DONE: if (flash_wr) begin
        next_latch_addr = addr;
        next_seq        = FBP_LATCHED;
      end
      FBP_LATCHED:   ;
      default:       next_seq = FBP_IDLE;
    endcase
    if (ctrl_wr) begin
      next_ctrl.mass           = wdata[`FBP_MASS_BIT];
      // Program and erase are interlocked; a write asking for both changes neither
      if (!(wdata[`FBP_PGM_BIT] && wdata[`FBP_ERASE_BIT]) &&
          !(wdata[`FBP_PGM_BIT] && ctrl.erase) &&
          !(wdata[`FBP_ERASE_BIT] && ctrl.program_select)) begin
        next_ctrl.program_select = wdata[`FBP_PGM_BIT];
        next_ctrl.erase          = wdata[`FBP_ERASE_BIT];
      end
      // Clearing high voltage is never refused, so software can always back out
      if (!wdata[`FBP_HIGH_VOLTAGE_ENABLE_BIT]) next_ctrl.high_voltage_enable = 1'b0;
      else if ((ctrl.program_select || ctrl.erase) && (seq == FBP_LATCHED) && !blocked)
        next_ctrl.high_voltage_enable = 1'b1;
      if (!wdata[`FBP_PGM_BIT] && !wdata[`FBP_ERASE_BIT]) next_seq = FBP_IDLE;
    end
    // Read data stand only in the cycle after the strobe; other cycles read zero
    if (rd) begin
      if (addr == `FBP_CTRL_ADDR)
        next_rdata = {4'h0, ctrl.high_voltage_enable, ctrl.mass, ctrl.erase,
                      ctrl.program_select};
      else if (addr == `FBP_BOUNDARY_ADDR)
        next_rdata = boundary_bits;
    end
  end

  // The boundary byte itself has no reset here: it lives in the array
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl       <= fbp_ctrl_t'(4'(`FBP_CTRL_RESET));
      seq        <= FBP_IDLE;
      latch_addr <= 16'h0000;
      rdata_q    <= 8'h00;
    end else begin
      ctrl       <= next_ctrl;
      seq        <= next_seq;
      latch_addr <= next_latch_addr;
      rdata_q    <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array programming strobes, including the boundary byte itself
  logic        nv_wr_q, next_nv_wr;
  logic [15:0] nv_addr_q, next_nv_addr;
  logic [7:0]  nv_data_q, next_nv_data;
  // Address and data follow the bus every cycle; only the strobe is gated, so the
  // array sees a stable pair in the one cycle in which nv_write stands.
  // Limitation: the gate uses the latched target, not each later write address
  always_comb begin
    next_nv_wr   = flash_wr && ctrl.program_select && ctrl.high_voltage_enable &&
                   !blocked;
    next_nv_addr = addr;
    next_nv_data = wdata;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nv_wr_q   <= 1'b0;
      nv_addr_q <= 16'h0000;
      nv_data_q <= 8'h00;
    end else begin
      nv_wr_q   <= next_nv_wr;
      nv_addr_q <= next_nv_addr;
      nv_data_q <= next_nv_data;
    end
  end

  assign rdata               = rdata_q;
  assign nv_write            = nv_wr_q;
  assign nv_addr             = nv_addr_q;
  assign nv_data             = nv_data_q;
  assign high_voltage_enable = ctrl.high_voltage_enable;
  assign program_select      = ctrl.program_select;
  assign erase_select        = ctrl.erase;
  assign mass_select         = ctrl.mass;
  assign target_blocked      = blocked;

  ////////////////////////////////////////////////////////////////////////////
  // Gating checks: each watches what this module drives
  a_hv_needs_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(high_voltage_enable) |-> $past(program_select || erase_select))
    else $error("high voltage rose without a select bit");
  a_hv_not_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(high_voltage_enable) |-> !$past(blocked))
    else $error("high voltage rose for a protected target");
  a_hv_after_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(high_voltage_enable) |-> $past(seq) == FBP_LATCHED)
    else $error("high voltage rose before the sequence completed");
  a_vector_locked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (latch_addr >= `FBP_VECT_LO) && !(ctrl.erase && ctrl.mass) |-> blocked)
    else $error("vector page not protected");
  a_full_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (boundary_bits == 8'h20) && (latch_addr >= `FBP_USER_LO) && !ctrl.mass |-> blocked)
    else $error("boundary 20 did not lock the array");
  a_open_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    open_all && (latch_addr <= `FBP_USER_HI) |-> !blocked)
    else $error("open boundary value blocked user array");
  a_self_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (boundary_bits != `FBP_ERASED) && (latch_addr == `FBP_BOUNDARY_ADDR) && !ctrl.mass
    |-> blocked)
    else $error("boundary byte not self protected");
  a_start_page: assert property (@(posedge clk_sys) disable iff (!rst_n)
    start_addr[15] && (start_addr[6:0] == 7'h00))
    else $error("start address off page boundary");
  a_interlock: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(program_select && erase_select))
    else $error("program and erase both selected");
  a_nv_write_hv: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nv_write |-> $past(ctrl.high_voltage_enable && ctrl.program_select))
    else $error("array written without programming sequence");
  a_above_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !open_all && (latch_addr >= start_addr) && !ctrl.mass |-> blocked)
    else $error("address above start not protected");
  a_start_in_array: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !open_all |-> (start_addr >= `FBP_USER_LO) && (start_addr <= `FBP_USER_HI))
    else $error("protection start outside the user array");
  a_self_open: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (boundary_bits == `FBP_ERASED) && (latch_addr == `FBP_BOUNDARY_ADDR) |-> !blocked)
    else $error("erased boundary byte was locked");
  a_nv_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nv_write |-> !$past(blocked))
    else $error("array written for a protected target");

  // Sequence and bus checks
  a_hv_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl_wr && !wdata[`FBP_HIGH_VOLTAGE_ENABLE_BIT] |=> !high_voltage_enable)
    else $error("high voltage not cleared on request");
  a_latch_on_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (seq == FBP_READ_DONE) && flash_wr |=> (latch_addr == $past(addr)))
    else $error("dummy write did not latch the target");
  a_seq_needs_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (seq == FBP_READ_DONE) && ($past(seq) != FBP_READ_DONE) |->
    $past(rd && (addr == `FBP_BOUNDARY_ADDR)))
    else $error("sequence advanced without a boundary read");
  a_rdata_boundary: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rd && (addr == `FBP_BOUNDARY_ADDR)) |-> (rdata == $past(boundary_bits)))
    else $error("boundary read returned a wrong value");
  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(rd) |-> (rdata == 8'h00))
    else $error("read data not zero outside a read");
endmodule
`default_nettype wire

// [test/fbp_array_model.sv]
// Nonvolatile array model holding the protect byte
`default_nettype none
module fbp_array_model (
  input  wire logic        clk_sys,
  input  wire logic        nv_write,
  input  wire logic [15:0] nv_addr,
  input  wire logic [7:0]  nv_data,
  input  wire logic        high_voltage_enable,
  input  wire logic        erase_select,
  input  wire logic        mass_select,
  output logic      [7:0]  boundary_bits,
  output int               writes
);
  timeunit 1ns;
  timeprecision 1ns;
  initial boundary_bits = 8'hFF;
  initial writes = 0;
  // No reset input: the byte lives in the array and survives any reset
  always @(posedge clk_sys) begin
    if (nv_write) begin
      writes <= writes + 1;
      // Programming can only clear bits, as in a real cell
      if (nv_addr == 16'hFFCF) boundary_bits <= boundary_bits & nv_data;
    end
    if (high_voltage_enable && erase_select && mass_select) boundary_bits <= 8'hFF;
  end
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Register-level bench for the flash block protection block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 0, rst_n = 0, wr = 0, rd = 0, nv_write, target_blocked;
  logic        high_voltage_enable, program_select, erase_select, mass_select;
  logic [15:0] addr = 16'h0000, nv_addr;
  logic [7:0]  wdata = 8'h00, rdata, boundary_bits, nv_data;
  int          miscompares = 0, tests_run = 0, writes, n;
  logic [7:0]  vals [7] = '{8'h00, 8'h1F, 8'h20, 8'h21, 8'hDF, 8'hE0, 8'hFF};
  logic [15:0] probes [6] = '{16'h9000, 16'h9080, 16'hEF80, 16'hEFFF, 16'hFFCF, 16'hFFD0};

  fbp_protect fbp_protect_inst (.clk_sys, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .boundary_bits, .nv_write, .nv_addr, .nv_data, .high_voltage_enable,
    .program_select, .erase_select, .mass_select, .target_blocked);
  fbp_array_model fbp_array_model_inst (.clk_sys, .nv_write, .nv_addr, .nv_data,
    .high_voltage_enable, .erase_select, .mass_select, .boundary_bits, .writes);

  initial forever #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Select, read the boundary, then latch the target with a dummy write
  task automatic arm(input logic [15:0] a, input logic [7:0] sel);
    logic [7:0] d;
    wreg(16'hFE08, sel);
    rreg(16'hFFCF, d);
    wreg(a, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #500us;
    miscompares++;
    stop_test();
  end
  initial begin
    logic [7:0]  d;
    logic [15:0] st;
    logic        e;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rreg(16'hFE08, d);
    chk("ctrl reset", d, 8'h00);
    rreg(16'h1234, d);
    chk("unmapped", d, 8'h00);
    wreg(16'hFE08, 8'h03);
    rreg(16'hFE08, d);
    chk("both selects", d, 8'h00);
    wreg(16'hFE08, 8'h01);
    wreg(16'h9000, 8'h00);
    wreg(16'hFE08, 8'h09);
    rreg(16'hFE08, d);
    chk("hv without read", d, 8'h01);
    wreg(16'hFE08, 8'h00);
    foreach (vals[i]) begin
      arm(16'h9000, 8'h06);
      wreg(16'hFE08, 8'h0E);
      wreg(16'hFE08, 8'h00);
      rreg(16'hFFCF, d);
      chk("mass erase", d, 8'hFF);
      if (vals[i] != 8'hFF) begin
        arm(16'hFFCF, 8'h01);
        wreg(16'hFE08, 8'h09);
        wreg(16'hFFCF, vals[i]);
        wreg(16'hFE08, 8'h00);
      end
      rreg(16'hFFCF, d);
      chk("boundary", d, vals[i]);
      st = {1'b1, vals[i], 7'h00};
      foreach (probes[j]) begin
        e = probes[j] >= 16'hFFD0 || (probes[j] == 16'hFFCF && vals[i] != 8'hFF)
            || (vals[i] inside {[8'h20:8'hDF]} && probes[j] >= st);
        arm(probes[j], 8'h01);
        #1 chk("blocked", target_blocked, e);
        n = writes;
        wreg(16'hFE08, 8'h09);
        rreg(16'hFE08, d);
        chk("hv", d, e ? 8'h01 : 8'h09);
        wreg(probes[j], 8'h5A);
        #1 chk("nv write", nv_write, !e);
        chk("nv addr", nv_addr, probes[j]);
        chk("nv data", nv_data, 8'h5A);
        @(posedge clk_sys);
        #1 chk("writes", 16'(writes), 16'(n + !e));
        wreg(16'hFE08, 8'h00);
      end
    end
    // Open byte was programmed with 5A by the last probe pass
    wreg(16'hFE08, 8'h01);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rreg(16'hFE08, d);
    chk("ctrl after reset", d, 8'h00);
    rreg(16'hFFCF, d);
    chk("boundary after reset", d, 8'h5A);
    stop_test();
  end
endmodule
`default_nettype wire
